// ==== verilog/nfc_host.sv ====
// host controller for an asynchronous nor flash: apb registers to pin cycles
// assumes a 10 MHz clock, a flash with a ready_busy_n open-drain output
// and software that polls the irq register or uses the irq pin
`timescale 1ns/1ps
module nfc_host
    import nfc_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic                   o_irq,
    output logic      [NFC_AW-1:0] o_addr,
    output logic      [NFC_DW-1:0] o_dq,
    output logic                   o_dq_oe,
    input  wire logic [NFC_DW-1:0] i_dq,
    output logic                   o_ce_n,
    output logic                   o_oe_n,
    output logic                   o_we_n,
    output logic                   o_reset_n,
    output logic                   o_unprotect_high_voltage,
    input  wire logic              i_ready_busy_n
);
    // every register of the block except the dq capture flops and the ready synchroniser lives in this one struct
    typedef struct packed {
        // sequencer and software registers
        nfc_state_t              st;
        logic [NFC_CW-1:0]       cnt;
        logic [7:0]              ctrl;
        logic [NFC_AW-1:0]       addr;
        logic [NFC_DW-1:0]       wdata;
        logic [NFC_DW-1:0]       rdata;
        logic [NFC_IRQ_W-1:0]    irq;
        logic [NFC_IRQ_W-1:0]    mask;
        logic                    busy;
        // apb answer and irq pin, registered
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        logic                    irq_o;
        // flash pins and ready history, registered
        logic [NFC_AW-1:0]       pa;
        logic [NFC_DW-1:0]       pd;
        logic                    dq_oe;
        logic                    ce_n;
        logic                    oe_n;
        logic                    we_n;
        logic                    reset_n;
        logic                    unprotect_high_voltage;
        logic                    rb_q;
    } nfc_s_t;

    nfc_s_t s_r;
    nfc_s_t s_nxt;
    logic   rb_sync;

    // ready_busy_n and dq are pins; ready_busy_n is synchronised
    nfc_sync u_rb_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   (i_ready_busy_n),
        .o_sync    (rb_sync)
    );

    // dq pin capture through two flops
    logic [NFC_DW-1:0] dq_m_r;
    logic [NFC_DW-1:0] dq_s_r;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            dq_m_r <= 8'h00;
            dq_s_r <= 8'h00;
        end else begin
            dq_m_r <= i_dq;
            dq_s_r <= dq_m_r;
        end
    end

    // next-state: apb slave, pin sequencer, interrupt status
    always_comb begin
        logic               wr_acc;
        logic               rd_acc;
        logic [NFC_IRQ_W-1:0] set;
        logic [NFC_IRQ_W-1:0] clr;

        // hold every register unless a branch below changes it
        s_nxt   = s_r;
        set     = '0;
        clr     = '0;
        // pready answers one cycle after the access phase is seen
        wr_acc  = i_psel && i_penable && i_pwrite && !s_r.pready;
        rd_acc  = i_psel && i_penable && !i_pwrite && !s_r.pready;
        s_nxt.pready  = i_psel && i_penable && !s_r.pready;
        s_nxt.pslverr = 1'b0;
        s_nxt.rb_q    = rb_sync;

        // ready edge in any state sets the ready status
        if (rb_sync && !s_r.rb_q) begin
            set[NFC_IRQ_READY] = 1'b1;
        end

        // register writes; go is taken only when idle
        if (wr_acc) begin
            if (i_paddr == NFC_REG_CTRL) begin
                s_nxt.ctrl = i_pwdata[7:0];
            end else if (i_paddr == NFC_REG_ADDR) begin
                s_nxt.addr = i_pwdata[NFC_AW-1:0];
            end else if (i_paddr == NFC_REG_WDATA) begin
                s_nxt.wdata = i_pwdata[NFC_DW-1:0];
            end else if (i_paddr == NFC_REG_IRQ) begin
                clr = i_pwdata[NFC_IRQ_W-1:0];
            end else if (i_paddr == NFC_REG_MASK) begin
                s_nxt.mask = i_pwdata[NFC_IRQ_W-1:0];
            end else if (i_paddr != NFC_REG_RDATA && i_paddr != NFC_REG_STATUS) begin
                s_nxt.pslverr = 1'b1;
            end
        end

        // register reads
        s_nxt.prdata = 32'h0000_0000;
        if (rd_acc) begin
            if (i_paddr == NFC_REG_CTRL) begin
                s_nxt.prdata = {24'h00_0000, s_r.ctrl};
            end else if (i_paddr == NFC_REG_ADDR) begin
                s_nxt.prdata = {9'h000, s_r.addr};
            end else if (i_paddr == NFC_REG_WDATA) begin
                s_nxt.prdata = {24'h00_0000, s_r.wdata};
            end else if (i_paddr == NFC_REG_RDATA) begin
                s_nxt.prdata = {24'h00_0000, s_r.rdata};
            end else if (i_paddr == NFC_REG_STATUS) begin
                s_nxt.prdata = {28'h000_0000, s_r.unprotect_high_voltage, !s_r.reset_n, rb_sync, s_r.busy};
            end else if (i_paddr == NFC_REG_IRQ) begin
                s_nxt.prdata = {30'h0000_0000, s_r.irq};
            end else if (i_paddr == NFC_REG_MASK) begin
                s_nxt.prdata = {30'h0000_0000, s_r.mask};
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end

        // pin sequencer: one flash cycle per go, pins change only on clock edges,
        // so every pulse width and gap is a whole number of 100 ns cycles;
        // the flash answers on its own time, so completion is taken from the
        // synced ready_busy_n, when waitrb is set, only after the busy delay has surely passed
        case (s_r.st)
            // idle: strobes high, go starts a cycle, dropping unprotect ends it
            NFC_IDLE: begin
                s_nxt.ce_n  = 1'b1;
                s_nxt.oe_n  = 1'b1;
                s_nxt.we_n  = 1'b1;
                s_nxt.dq_oe = 1'b0;
                if (s_nxt.ctrl[NFC_CTRL_GO]) begin
                    s_nxt.ctrl[NFC_CTRL_GO] = 1'b0;
                    s_nxt.busy = 1'b1;
                    s_nxt.pa   = s_nxt.addr;
                    s_nxt.pd   = s_nxt.wdata;
                    s_nxt.cnt  = '0;
                    // group protect and unprotect force the select address bits
                    if (s_nxt.ctrl[NFC_CTRL_PROT]) begin
                        s_nxt.pa[NFC_PSEL_BIT] = 1'b0;
                        s_nxt.pa[NFC_A1_BIT]   = 1'b1;
                        s_nxt.pa[NFC_A0_BIT]   = 1'b0;
                    end else if (s_nxt.ctrl[NFC_CTRL_UNPGRP]) begin
                        s_nxt.pa[NFC_PSEL_BIT] = 1'b1;
                        s_nxt.pa[NFC_A1_BIT]   = 1'b1;
                        s_nxt.pa[NFC_A0_BIT]   = 1'b0;
                    end
                    // reset wins and ends the go; otherwise the elevated level if not already up
                    if (s_nxt.ctrl[NFC_CTRL_RESET]) begin
                        s_nxt.reset_n = 1'b0;
                        s_nxt.st = NFC_RSTP;
                    end else if (s_nxt.ctrl[NFC_CTRL_UNPROT] && !s_r.unprotect_high_voltage) begin
                        s_nxt.unprotect_high_voltage = 1'b1;
                        s_nxt.st = NFC_RSP;
                    end else begin
                        s_nxt.st = NFC_SETUP;
                    end
                end else if (!s_nxt.ctrl[NFC_CTRL_UNPROT] && s_r.unprotect_high_voltage) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.cnt  = '0;
                    s_nxt.st   = NFC_RRB;
                end
            end

            // elevated level stands before the first strobe
            NFC_RSP: begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt == NFC_CW'(NFC_UNPROTECT_SETUP_TIME_CYC - 1)) begin
                    s_nxt.cnt = '0;
                    s_nxt.st = NFC_SETUP;
                end
            end

            NFC_SETUP: begin
                // address and data set up, chip enable and the strobe fall together
                s_nxt.dq_oe = !s_r.ctrl[NFC_CTRL_RD];
                if (s_r.ctrl[NFC_CTRL_RD]) begin
                    s_nxt.ce_n = 1'b0;
                    s_nxt.oe_n = 1'b0;
                end else if (s_r.ctrl[NFC_CTRL_CEMODE]) begin
                    s_nxt.we_n = 1'b0;
                    s_nxt.ce_n = 1'b0;
                end else begin
                    s_nxt.ce_n = 1'b0;
                    s_nxt.we_n = 1'b0;
                end
                s_nxt.cnt = '0;
                s_nxt.st  = NFC_STROBE;
            end

            // strobe low; a read stays low two cycles more for the dq synchroniser
            NFC_STROBE: begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                if ((s_r.ctrl[NFC_CTRL_RD] && s_r.cnt == NFC_CW'(NFC_TSTRB_CYC + 1)) ||
                    (!s_r.ctrl[NFC_CTRL_RD] && s_r.cnt == NFC_CW'(NFC_TSTRB_CYC - 1))) begin
                    // read data: dq as the flash drove it during the strobe
                    if (s_r.ctrl[NFC_CTRL_RD]) begin
                        s_nxt.rdata = dq_s_r;
                        s_nxt.oe_n  = 1'b1;
                        s_nxt.ce_n  = 1'b1;
                    end else if (s_r.ctrl[NFC_CTRL_CEMODE]) begin
                        s_nxt.ce_n = 1'b1;
                    end else begin
                        s_nxt.we_n = 1'b1;
                    end
                    s_nxt.cnt = '0;
                    s_nxt.st  = NFC_GAP;
                end
            end

            // strobes high until the write cycle time is met
            NFC_GAP: begin
                s_nxt.we_n  = 1'b1;
                s_nxt.ce_n  = 1'b1;
                s_nxt.dq_oe = 1'b0;
                s_nxt.cnt   = s_r.cnt + 8'h01;
                if (s_r.cnt >= NFC_CW'(NFC_TWC_CYC - NFC_TSTRB_CYC)) begin
                    s_nxt.cnt = '0;
                    s_nxt.st = s_r.ctrl[NFC_CTRL_WAITRB] ? NFC_BUSYW : NFC_IDLE;
                    if (!s_r.ctrl[NFC_CTRL_WAITRB]) begin
                        s_nxt.busy = 1'b0;
                        set[NFC_IRQ_DONE] = 1'b1;
                    end
                end
            end

            NFC_BUSYW: begin
                // allow the device its busy delay before sampling
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt >= NFC_CW'(NFC_BUSY_ASSERT_DELAY_CYC + 2)) begin
                    s_nxt.st = NFC_WAITRB;
                end
            end

            // completion: synced ready seen high
            NFC_WAITRB: begin
                if (rb_sync) begin
                    s_nxt.busy = 1'b0;
                    s_nxt.st   = NFC_IDLE;
                    set[NFC_IRQ_DONE] = 1'b1;
                end
            end

            // hold the elevated level while ready stands
            NFC_RRB: begin
                // any busy restarts the hold count
                if (!rb_sync) begin
                    s_nxt.cnt = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt + 8'h01;
                end
                if (rb_sync && s_r.cnt == NFC_CW'(NFC_UNPROTECT_HOLD_TIME_CYC - 1)) begin
                    s_nxt.unprotect_high_voltage  = 1'b0;
                    s_nxt.busy = 1'b0;
                    s_nxt.st   = NFC_IDLE;
                    set[NFC_IRQ_DONE] = 1'b1;
                end
            end

            // flash reset pulse, then wait for ready
            NFC_RSTP: begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt == NFC_CW'(NFC_TRP_CYC - 1)) begin
                    s_nxt.reset_n = 1'b1;
                    s_nxt.ctrl[NFC_CTRL_RESET] = 1'b0;
                    s_nxt.cnt = '0;
                    s_nxt.st = NFC_WAITRB;
                end
            end

            default: begin
                s_nxt.st = NFC_IDLE;
            end
        endcase

        // sticky status: set wins over write-one clear
        s_nxt.irq   = (s_r.irq & ~clr) | set;
        s_nxt.irq_o = |(s_nxt.irq & s_nxt.mask);
    end

    // state register
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_r         <= '0;
            s_r.ctrl    <= NFC_CTRL_RST[7:0];
            // strobes, flash reset and the ready history rest high
            s_r.st      <= NFC_IDLE;
            s_r.ce_n    <= 1'b1;
            s_r.oe_n    <= 1'b1;
            s_r.we_n    <= 1'b1;
            s_r.reset_n <= 1'b1;
            s_r.rb_q    <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign o_prdata                 = s_r.prdata;
    assign o_pready                 = s_r.pready;
    assign o_pslverr                = s_r.pslverr;
    assign o_irq                    = s_r.irq_o;

    // flash pins
    assign o_addr                   = s_r.pa;
    assign o_dq                     = s_r.pd;
    assign o_dq_oe                  = s_r.dq_oe;
    assign o_ce_n                   = s_r.ce_n;
    assign o_oe_n                   = s_r.oe_n;
    assign o_we_n                   = s_r.we_n;
    assign o_reset_n                = s_r.reset_n;
    assign o_unprotect_high_voltage = s_r.unprotect_high_voltage;
endmodule

// ==== verilog/nfc_pkg.sv ====
// package for the nor flash host controller: register map, pin timing, states
// assumes a 10 MHz system clock and an asynchronous parallel nor flash outside
// Functional notes
// - status reads strobed by output or chip enable
// - progress toggle read needs no valid address
// - protect uses addr bit6 low, bit1 high
// - unprotect uses addr bit6 high, bit1 high
// - new write right after ready, no delay
// - unprotect voltage 4 us before first write
// - unprotect voltage held 4 us after ready
// - chip-enable timed writes with write low
// - writes spaced one write cycle apart
package nfc_pkg;
    // register byte offsets on the apb side
    localparam logic [7:0]  NFC_REG_CTRL    = 8'h00;
    localparam logic [7:0]  NFC_REG_ADDR    = 8'h04;
    localparam logic [7:0]  NFC_REG_WDATA   = 8'h08;
    localparam logic [7:0]  NFC_REG_RDATA   = 8'h0C;
    localparam logic [7:0]  NFC_REG_STATUS  = 8'h10;
    localparam logic [7:0]  NFC_REG_IRQ     = 8'h14;
    localparam logic [7:0]  NFC_REG_MASK    = 8'h18;
    // ctrl fields
    localparam int          NFC_CTRL_GO     = 0;
    localparam int          NFC_CTRL_RD     = 1;
    localparam int          NFC_CTRL_CEMODE = 2;
    localparam int          NFC_CTRL_WAITRB = 3;
    localparam int          NFC_CTRL_UNPROT = 4;
    localparam int          NFC_CTRL_RESET  = 5;
    localparam int          NFC_CTRL_PROT   = 6;
    localparam int          NFC_CTRL_UNPGRP = 7;
    // address bits that select group protect and unprotect
    localparam int          NFC_PSEL_BIT    = 6;
    localparam int          NFC_A1_BIT      = 1;
    localparam int          NFC_A0_BIT      = 0;
    // irq bits
    localparam int          NFC_IRQ_DONE    = 0;
    localparam int          NFC_IRQ_READY   = 1;
    localparam int          NFC_IRQ_W       = 2;
    localparam logic [31:0] NFC_CTRL_RST    = 32'h0000_0000;
    // pin widths
    localparam int          NFC_AW          = 23;
    localparam int          NFC_DW          = 8;
    // timing in ns and derived cycle counts at 100 ns per cycle
    localparam int          NFC_CLK_NS      = 100;
    localparam int          NFC_TWC_NS      = 120;
    localparam int          NFC_TSTRB_NS    = 50;
    localparam int          NFC_UNPROTECT_SETUP_TIME_NS     = 4000;
    localparam int          NFC_UNPROTECT_HOLD_TIME_NS     = 4000;
    localparam int          NFC_TRP_NS      = 500;
    localparam int          NFC_BUSY_ASSERT_DELAY_NS    = 90;
    localparam int          NFC_TWC_CYC     = (NFC_TWC_NS + NFC_CLK_NS - 1) / NFC_CLK_NS;
    localparam int          NFC_TSTRB_CYC   = (NFC_TSTRB_NS + NFC_CLK_NS - 1) / NFC_CLK_NS;
    localparam int          NFC_UNPROTECT_SETUP_TIME_CYC    = (NFC_UNPROTECT_SETUP_TIME_NS + NFC_CLK_NS - 1) / NFC_CLK_NS;
    localparam int          NFC_UNPROTECT_HOLD_TIME_CYC    = (NFC_UNPROTECT_HOLD_TIME_NS + NFC_CLK_NS - 1) / NFC_CLK_NS;
    localparam int          NFC_TRP_CYC     = (NFC_TRP_NS + NFC_CLK_NS - 1) / NFC_CLK_NS;
    localparam int          NFC_BUSY_ASSERT_DELAY_CYC   = (NFC_BUSY_ASSERT_DELAY_NS + NFC_CLK_NS - 1) / NFC_CLK_NS;
    localparam int          NFC_CW          = 8;
    // pin cycle states
    typedef enum logic [3:0] {
        NFC_IDLE,
        NFC_RSP,
        NFC_SETUP,
        NFC_STROBE,
        NFC_GAP,
        NFC_BUSYW,
        NFC_WAITRB,
        NFC_RRB,
        NFC_RSTP
    } nfc_state_t;
endpackage

// ==== verilog/nfc_sync.sv ====
// two flop synchroniser for one pin input
// assumes the pin is asynchronous to i_clk_sys
`timescale 1ns/1ps
module nfc_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_r;
    // first flop feeds only the second
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= 1'b1;
            o_sync <= 1'b1;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// ==== dv/nfc_checker.sv ====
// checker for the nor flash host: apb handshake and flash pin timing
// assumes it is bound to nfc_host and sees only that module's ports
`timescale 1ns/1ps
module nfc_checker
    import nfc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_dq_oe,
    input wire logic o_ce_n,
    input wire logic o_oe_n,
    input wire logic o_we_n,
    input wire logic o_reset_n,
    input wire logic o_unprotect_high_voltage,
    input wire logic i_ready_busy_n
);
    logic [7:0] vid_cnt_r;
    logic [7:0] rb_cnt_r;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // cycles the elevated level has stood, and cycles ready has stood
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            vid_cnt_r <= 8'h00;
            rb_cnt_r  <= 8'h00;
        end else begin
            vid_cnt_r <= !o_unprotect_high_voltage ? 8'h00 :
                         (vid_cnt_r == 8'hFF) ? vid_cnt_r : vid_cnt_r + 8'h01;
            rb_cnt_r  <= !i_ready_busy_n ? 8'h00 :
                         (rb_cnt_r == 8'hFF) ? rb_cnt_r : rb_cnt_r + 8'h01;
        end
    end
    sequence s_gap;
        (o_ce_n || o_we_n) ##1 (o_ce_n || o_we_n);
    endsequence
    sequence s_take;
        i_psel && i_penable && !o_pready;
    endsequence
    property p_answer;  s_take |=> o_pready; endproperty
    property p_pulse;   o_pready |=> !o_pready; endproperty
    property p_err;     o_pslverr |-> o_pready; endproperty
    property p_spacing; $fell(o_ce_n || o_we_n) |=> s_gap; endproperty
    property p_no_clash; !o_oe_n |-> !o_dq_oe && o_we_n; endproperty
    property p_vid_setup;
        $fell(o_ce_n) && o_unprotect_high_voltage |-> vid_cnt_r >= NFC_UNPROTECT_SETUP_TIME_CYC;
    endproperty
    property p_vid_hold; $fell(o_unprotect_high_voltage) |-> rb_cnt_r >= NFC_UNPROTECT_HOLD_TIME_CYC; endproperty
    property p_rst_width; $fell(o_reset_n) |-> (!o_reset_n) [*5]; endproperty
    a_answer:   assert property (p_answer) else $error("no ready after access");
    a_pulse:    assert property (p_pulse) else $error("ready longer than one cycle");
    a_err:      assert property (p_err) else $error("error without ready");
    a_spacing:  assert property (p_spacing) else $error("strobe too long");
    a_no_clash: assert property (p_no_clash) else $error("read with drive");
    a_vid_setup: assert property (p_vid_setup) else $error("strobe too soon");
    a_vid_hold: assert property (p_vid_hold) else $error("level dropped early");
    a_rst_width: assert property (p_rst_width) else $error("reset too short");
endmodule
bind nfc_host nfc_checker u_chk (.i_clk_sys, .i_rst, .i_psel, .i_penable, .o_pready,
    .o_pslverr, .o_dq_oe, .o_ce_n, .o_oe_n, .o_we_n, .o_reset_n,
    .o_unprotect_high_voltage, .i_ready_busy_n);

// ==== dv/nfc_flash_model.sv ====
// behavioural nor flash: byte program with busy time, status bits, reset abort
// assumes host pins of nfc_host; every write cycle is taken as a byte program
`timescale 1ns/1ps
module nfc_flash_model
    import nfc_pkg::*;
#(
    parameter int PROG_NS  = 5000, // busy time of any algorithm
    parameter int ABORT_NS = 2000  // abort to read mode, under 20 us
)(
    input  wire logic [NFC_AW-1:0] i_addr,
    input  wire logic [NFC_DW-1:0] i_dq,
    input  wire logic              i_ce_n,
    input  wire logic              i_oe_n,
    input  wire logic              i_we_n,
    input  wire logic              i_reset_n,
    output logic      [NFC_DW-1:0] o_q,
    output logic                   o_ready_busy_n
);
    logic [7:0] mem [256];
    logic [NFC_AW-1:0] addr_lat;
    logic [7:0] data_lat;
    logic busy = 1'b0;
    logic tog = 1'b0;
    wire wr_act = !i_we_n && !i_ce_n && i_reset_n;
    wire rd_act = !i_oe_n && !i_ce_n;
    event go;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        o_ready_busy_n = 1'b1;
    end
    // address at the later falling strobe, data at the first rising
    always @(posedge wr_act) addr_lat = i_addr;
    always @(negedge wr_act) if (i_reset_n) begin
        data_lat = i_dq;
        ->go;
    end
    // busy 50 ns after the write, ready when done
    always @(go) begin : alg
        busy = 1'b1;
        #50 o_ready_busy_n = 1'b0;
        #(PROG_NS) mem[addr_lat[7:0]] = data_lat;
        busy = 1'b0;
        o_ready_busy_n = 1'b1;
    end
    // reset aborts a running program, then ready again
    always @(negedge i_reset_n) begin
        disable alg;
        if (busy) #(ABORT_NS);
        busy = 1'b0;
        o_ready_busy_n = 1'b1;
    end
    // each read ended by either strobe while busy flips the progress bit
    always @(negedge rd_act) if (busy) tog = !tog;
    // status at any address, suspend bit still, nothing suspended
    // outside a read the bus floats; the inverse shows a sample taken off the strobe
    wire [7:0] q_val = busy ? {~data_lat[7], tog, 6'h00} : mem[i_addr[7:0]];
    assign o_q = rd_act ? q_val : ~q_val;
endmodule

// ==== dv/tb_top.sv ====
// top bench: apb master tasks, flash model, checker bound to the host
// assumes nfc_pkg, nfc_host, the model and the checker are compiled first
`timescale 1ns/1ps
module tb_top;
    import nfc_pkg::*;
    localparam logic [31:0] GO  = 32'h1 << NFC_CTRL_GO;
    localparam logic [31:0] RD  = 32'h1 << NFC_CTRL_RD;
    localparam logic [31:0] CE  = 32'h1 << NFC_CTRL_CEMODE;
    localparam logic [31:0] WRB = 32'h1 << NFC_CTRL_WAITRB;
    localparam logic [31:0] UNP = 32'h1 << NFC_CTRL_UNPROT;
    localparam logic [31:0] RST = 32'h1 << NFC_CTRL_RESET;
    localparam logic [31:0] PRT = 32'h1 << NFC_CTRL_PROT;
    localparam logic [31:0] UPG = 32'h1 << NFC_CTRL_UNPGRP;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, perr, rerr, irq, fdq_oe, ce_n, oe_n, we_n, rst_n, unprotect_high_voltage, rb_n, msk;
    logic [NFC_AW-1:0] fa;
    logic [NFC_DW-1:0] fdq, fq;
    wire [NFC_DW-1:0] dq_in = fdq_oe ? fdq : fq;
    int fail_count = 0;
    int comparisons = 0;
    nfc_host DUT (.i_clk_sys, .i_rst, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(perr), .o_irq(irq), .o_addr(fa), .o_dq(fdq), .o_dq_oe(fdq_oe),
        .i_dq(dq_in), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_reset_n(rst_n),
        .o_unprotect_high_voltage(unprotect_high_voltage), .i_ready_busy_n(rb_n));
    nfc_flash_model #(.PROG_NS(20000)) mdl (.i_addr(fa), .i_dq(fdq), .i_ce_n(ce_n),
        .i_oe_n(oe_n), .i_we_n(we_n), .i_reset_n(rst_n), .o_q(fq), .o_ready_busy_n(rb_n));
    always #50 i_clk_sys = ~i_clk_sys;
    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, request held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk_sys);
        pen <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) chk("pready timeout", {31'h0, pready}, 32'h1);
        rdat = prdata;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    // poll a register until the masked value matches
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rdat & m) !== v && n < 500);
        chk("poll", rdat & m, v);
    endtask
    // one flash cycle, then done flag, irq pin and clear
    task automatic op(input logic [31:0] ctl, input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, NFC_REG_ADDR, {24'h0, a});
        apb(1'b1, NFC_REG_WDATA, {24'h0, d});
        apb(1'b1, NFC_REG_CTRL, ctl | GO);
        poll(NFC_REG_IRQ, 32'h1, 32'h1);
        chk("irq pin", {31'h0, irq}, {31'h0, msk});
        apb(1'b1, NFC_REG_IRQ, 32'h3);
        chk("irq clear", {31'h0, irq}, 32'h0);
    endtask
    task automatic rflash(input logic [7:0] a);
        op(RD, a, 8'h00);
        apb(1'b0, NFC_REG_RDATA, 32'h0);
    endtask
    task automatic t_regs;
        apb(1'b0, NFC_REG_CTRL, 32'h0);
        chk("ctrl reset", rdat, NFC_CTRL_RST);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped error", {31'h0, rerr}, 32'h1);
        apb(1'b1, NFC_REG_STATUS, 32'hF);
        apb(1'b0, NFC_REG_STATUS, 32'h0);
        chk("status idle", rdat, 32'h2);
        $display("test regs done");
    endtask
    task automatic t_prog;
        for (int m = 0; m < 2; m++) begin
            msk = m[0];
            apb(1'b1, NFC_REG_MASK, {31'h0, msk});
            op(WRB | (msk ? CE : 32'h0), 8'h12 + 8'(m), 8'h5A + 8'(m));
            chk("latched addr", 32'(mdl.addr_lat), 32'h12 + m);
            rflash(8'h12 + 8'(m));
            chk("program data", rdat, 32'h5A + m);
        end
        msk = 1'b0;
        apb(1'b1, NFC_REG_MASK, 32'h0);
        $display("test prog done");
    endtask
    task automatic t_status;
        logic [31:0] s1;
        op(32'h0, 8'h34, 8'hC3);
        rflash(8'h99);
        s1 = rdat;
        chk("polling bit", rdat & 32'h80, 32'h00);
        rflash(8'h99);
        chk("toggle flips", (rdat ^ s1) & 32'h40, 32'h40);
        poll(NFC_REG_STATUS, 32'h3, 32'h2);
        rflash(8'h34);
        chk("array data", rdat, 32'hC3);
        rflash(8'h34);
        chk("toggle stopped", rdat, 32'hC3);
        $display("test status done");
    endtask
    task automatic t_reset;
        op(32'h0, 8'h40, 8'h00);
        op(RST, 8'h00, 8'h00);
        chk("ready after abort", {31'h0, rb_n}, 32'h1);
        rflash(8'h40);
        chk("aborted byte", rdat, 32'hFF);
        $display("test reset done");
    endtask
    task automatic t_unprot;
        op(UNP | PRT | WRB, 8'h00, 8'h00);
        chk("protect addr", 32'(mdl.addr_lat) & 32'h43, 32'h02);
        op(UNP | UPG | WRB, 8'h00, 8'h00);
        chk("unprotect addr", 32'(mdl.addr_lat) & 32'h43, 32'h42);
        apb(1'b1, NFC_REG_CTRL, 32'h0);
        poll(NFC_REG_STATUS, 32'h8, 32'h0);
        $display("test unprotect done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // main sequence after 16 cycles of reset
    initial begin
        msk = 1'b0;
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        t_regs();
        t_prog();
        t_status();
        t_reset();
        t_unprot();
        end_of_test();
    end
    // watchdog, well past the expected run length
    initial begin
        #3000000;
        fail_count++;
        end_of_test();
    end
endmodule
